// *** uart_baud_select_and_control.v ***
// serial port control: baud source selection, internal rate generator, control register, tx and rx engines
// Operation
// - tx clock: generator, else timer2, else timer1
// - rx clock selected the same way, independently
// - generator rate from reload, fast select, doubler
// - rate = 2^dbl*clk/(2*6^(1-fast)*16*(256-reload))
// - generator clocks variable-rate async modes, mode zero optionally
// - bad stop sets sticky framing fault flag while framing view selected
// - bit 7 is fault flag or upper mode
// - mode field selects shift, 8-bit, 9-bit frames
// - multiprocessor bit filters frames in uart modes
// - receiver ignores line while receive allow clear
// - transmit ninth bit sent in 9-bit modes
// - receive ninth bit gets ninth or stop bit
// - tx done set at stop start or bit8
// - rx done set after frame, cleared by software
// - framing detection moves rx done to stop
// - address frames accepted only on address match
// - doubler doubles rate in uart modes
`timescale 1ns/1ps
`default_nettype none
`include "uart_defs.vh"
module uart_baud_select_and_control #(
    parameter GEN_WIDTH = 8
) (
    input wire sys_clk, // peripheral clock, 10 MHz
    input wire arst_n, // asynchronous reset, active low
    input wire [7:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [31:0] avs_writedata, // write data
    output reg [31:0] avs_readdata, // read data
    output wire avs_waitrequest, // stall while read data is fetched
    input wire timer1_overflow, // timer 1 overflow pulse
    input wire timer2_overflow, // timer 2 overflow pulse
    input wire rxd_in, // receive line level
    output reg rxd_out, // shift mode data out
    output reg rxd_oe, // shift mode data drive enable
    output reg txd_out, // transmit line or shift clock
    output wire irq // level interrupt
);
    localparam RX_IDLE = 4'b0001;
    localparam RX_START = 4'b0010;
    localparam RX_DATA = 4'b0100;
    localparam RX_STOP = 4'b1000;

    reg mode_upper, mode_lower, multiproc_enable, rx_enable;
    reg tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag, framing_fault_flag;
    reg [GEN_WIDTH-1:0] generator_reload_value;
    reg [GEN_WIDTH-1:0] gen_count;
    reg generator_run, tx_generator_select, rx_generator_select;
    reg generator_fast_select, mode_zero_generator_select;
    reg tx_timer2_select, rx_timer2_select, baud_doubler, framing_view_select;
    reg [7:0] given_address, address_mask, rx_buffer;
    reg [2:0] irq_status, irq_enable;
    reg rd_ready;
    reg [3:0] pre_count;
    reg [1:0] m0_count;
    reg rx_meta, rx_sync, rx_prev;
    reg tx_busy, tx_phase;
    reg [10:0] tx_shift;
    reg [3:0] tx_bit, tx_sub;
    reg [3:0] rx_state, rx_bit, rx_sub;
    reg [8:0] rx_shift;
    reg rx_phase;
    reg [31:0] rd_mux;

    wire [1:0] mode = {mode_upper, mode_lower};
    wire mode0 = (mode == `MODE_SHIFT);
    wire nine = mode_upper;
    wire bus_wr_sc = avs_write && (avs_address == `OFF_SERIAL_CONTROL);
    wire bus_wr_data = avs_write && (avs_address == `OFF_DATA_BUFFER);
    wire bus_wr_clr = avs_write && (avs_address == `OFF_IRQ_CLEAR);

    // read takes one wait cycle so read data always comes from a flip-flop
    assign avs_waitrequest = avs_read && !rd_ready;

    // prescaler folds 2*6^(1-fast)/2^doubler into one divider ahead of the counter
    wire [3:0] base_div = generator_fast_select ? `GEN_FAST_DIV : `GEN_SLOW_DIV;
    wire [3:0] pre_div = baud_doubler ? base_div : {base_div[2:0], 1'b0};
    wire pre_tick = generator_run && (pre_count == pre_div - 4'h1);
    wire gen_ovf = pre_tick && (gen_count == {GEN_WIDTH{1'b1}});

    // mode zero shift clock: f/6 from a divide by three per half bit, or generator
    wire m0_tick = mode_zero_generator_select ? gen_ovf : (m0_count == `MODE_ZERO_HALF);

    // per direction oversample tick: index 0 transmit, 1 receive
    wire [1:0] dir_gen = {rx_generator_select, tx_generator_select};
    wire [1:0] dir_t2 = {rx_timer2_select, tx_timer2_select};
    wire [1:0] dir_tick;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_dir
            reg half;
            wire timer_src = dir_t2[gi] ? timer2_overflow : timer1_overflow;
            wire fixed_rate = (mode == `MODE_9BIT_FIXED);
            wire src = fixed_rate ? 1'b1 : (dir_gen[gi] ? gen_ovf : timer_src);
            // timers and fixed rate run at half speed unless doubled; generator doubling is in the prescaler
            wire need_half = !baud_doubler && (fixed_rate || !dir_gen[gi]);
            assign dir_tick[gi] = src && (!need_half || half);
            always @(posedge sys_clk or negedge arst_n)
            begin
                if (!arst_n)
                    half <= 1'b0;
                else if (src && need_half)
                    half <= !half;
            end
        end
    endgenerate

    // transmit timing
    wire tx_step = mode0 ? (m0_tick && tx_phase) : (dir_tick[0] && tx_sub == `SAMPLE_LAST);
    wire [3:0] tx_last = mode0 ? `BITS_SHIFT_LAST : (nine ? `BITS_9_LAST : `BITS_8_LAST);
    wire tx_set = tx_busy && tx_step && (mode0 ? (tx_bit == tx_last) : (tx_bit == tx_last - 4'h1));
    wire tx_end = tx_busy && tx_step && (tx_bit == tx_last);

    // receive completion; fin_word holds data low and ninth or stop in bit 8, data in bits 8:1 in mode zero
    wire rx_smp = mode0 ? (m0_tick && rx_phase) : (dir_tick[1] && rx_sub == `SAMPLE_LAST);
    wire [8:0] rx_next_shift = {rx_sync, rx_shift[8:1]};
    wire rx_in_data = (rx_state == RX_DATA);
    wire rx_in_stop = (rx_state == RX_STOP);
    wire fin_ninth_data = rx_in_data && !mode0 && nine && rx_bit == 4'h8 && rx_smp && !framing_view_select;
    wire fin_stop = rx_in_stop && rx_smp && (!nine || framing_view_select);
    wire fin_m0 = rx_in_data && mode0 && rx_bit == `BITS_SHIFT_LAST && rx_smp;
    wire rx_fin = fin_ninth_data || fin_stop || fin_m0;
    wire [8:0] fin_word = (rx_in_stop && nine) ? rx_shift : rx_next_shift;
    wire [7:0] fin_data = mode0 ? fin_word[8:1] : fin_word[7:0];
    wire fin_ninth = fin_word[8];
    // given address ignores mask zeros; broadcast needs ones wherever address or mask is one
    wire addr_given = (((fin_data ^ given_address) & address_mask) == 8'h00);
    wire addr_bcast = ((fin_data | ~(given_address | address_mask)) == 8'hff);
    wire rx_accept = rx_fin && rx_enable && !rx_done_flag &&
        (mode0 || !multiproc_enable || (fin_ninth && (addr_given || addr_bcast)));
    wire fe_set = rx_in_stop && rx_smp && !rx_sync && framing_view_select;

    assign irq = |(irq_status & irq_enable);

    // bus read mux
    always @*
    begin
        rd_mux = 32'h0;
        case (avs_address)
            `OFF_SERIAL_CONTROL: rd_mux[7:0] = {framing_view_select ? framing_fault_flag : mode_upper,
                mode_lower, multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
            `OFF_DATA_BUFFER: rd_mux[7:0] = rx_buffer;
            `OFF_RELOAD: rd_mux[GEN_WIDTH-1:0] = generator_reload_value;
            `OFF_GEN_CONTROL: rd_mux[4:0] = {generator_run, tx_generator_select, rx_generator_select,
                generator_fast_select, mode_zero_generator_select};
            `OFF_TIMER_TWO: rd_mux[5:4] = {rx_timer2_select, tx_timer2_select};
            `OFF_POWER: rd_mux[7:6] = {baud_doubler, framing_view_select};
            `OFF_ADDRESS: rd_mux[15:0] = {address_mask, given_address};
            `OFF_IRQ_STATUS: rd_mux[2:0] = irq_status;
            `OFF_IRQ_ENABLE: rd_mux[2:0] = irq_enable;
            default: rd_mux = 32'h0;
        endcase
    end

    // register file and sticky flags; hardware set wins over a software clear
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {mode_upper, mode_lower, multiproc_enable, rx_enable} <= 4'h0;
            {tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag} <= 4'h0;
            framing_fault_flag <= 1'b0;
            generator_reload_value <= {GEN_WIDTH{1'b0}};
            {generator_run, tx_generator_select, rx_generator_select} <= 3'h0;
            {generator_fast_select, mode_zero_generator_select} <= 2'h0;
            {tx_timer2_select, rx_timer2_select, baud_doubler, framing_view_select} <= 4'h0;
            given_address <= `ADDRESS_RST;
            address_mask <= `ADDRESS_RST;
            rx_buffer <= 8'h00;
            irq_status <= `IRQ_RST;
            irq_enable <= `IRQ_RST;
            rd_ready <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else
        begin
            rd_ready <= avs_read && !rd_ready;
            if (avs_read && !rd_ready)
                avs_readdata <= rd_mux;
            if (bus_wr_sc)
            begin
                if (!framing_view_select)
                    mode_upper <= avs_writedata[`SC_MODE_UPPER];
                mode_lower <= avs_writedata[`SC_MODE_LOWER];
                multiproc_enable <= avs_writedata[`SC_MULTIPROC];
                rx_enable <= avs_writedata[`SC_RX_ALLOW];
                tx_ninth_bit <= avs_writedata[`SC_TX_NINTH];
            end
            framing_fault_flag <= fe_set ||
                ((bus_wr_sc && framing_view_select) ? avs_writedata[`SC_MODE_UPPER] : framing_fault_flag);
            tx_done_flag <= tx_set || (bus_wr_sc ? avs_writedata[`SC_TX_DONE] : tx_done_flag);
            rx_done_flag <= rx_accept || (bus_wr_sc ? avs_writedata[`SC_RX_DONE] : rx_done_flag);
            if (rx_accept && !mode0)
                rx_ninth_bit <= fin_ninth;
            else if (bus_wr_sc)
                rx_ninth_bit <= avs_writedata[`SC_RX_NINTH];
            if (rx_accept)
                rx_buffer <= fin_data;
            if (avs_write && avs_address == `OFF_RELOAD)
                generator_reload_value <= avs_writedata[GEN_WIDTH-1:0];
            if (avs_write && avs_address == `OFF_GEN_CONTROL)
            begin
                generator_run <= avs_writedata[`GC_RUN];
                tx_generator_select <= avs_writedata[`GC_TX_GEN];
                rx_generator_select <= avs_writedata[`GC_RX_GEN];
                generator_fast_select <= avs_writedata[`GC_FAST];
                mode_zero_generator_select <= avs_writedata[`GC_MODE_ZERO];
            end
            if (avs_write && avs_address == `OFF_TIMER_TWO)
            begin
                tx_timer2_select <= avs_writedata[`T2_TX_SEL];
                rx_timer2_select <= avs_writedata[`T2_RX_SEL];
            end
            if (avs_write && avs_address == `OFF_POWER)
            begin
                baud_doubler <= avs_writedata[`PW_DOUBLER];
                framing_view_select <= avs_writedata[`PW_FRAMING_VIEW];
            end
            if (avs_write && avs_address == `OFF_ADDRESS)
            begin
                given_address <= avs_writedata[7:0];
                address_mask <= avs_writedata[15:8];
            end
            if (avs_write && avs_address == `OFF_IRQ_ENABLE)
                irq_enable <= avs_writedata[2:0];
            irq_status <= {fe_set, tx_set, rx_accept} |
                (irq_status & ~(bus_wr_clr ? avs_writedata[2:0] : 3'h0));
        end
    end

    // internal generator: prescaler then reloading up counter
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_count <= 4'h0;
            gen_count <= {GEN_WIDTH{1'b0}};
            m0_count <= 2'h0;
        end
        else
        begin
            m0_count <= (m0_count == `MODE_ZERO_HALF) ? 2'h0 : m0_count + 2'h1;
            if (!generator_run)
            begin
                pre_count <= 4'h0;
                gen_count <= generator_reload_value;
            end
            else if (pre_tick)
            begin
                pre_count <= 4'h0;
                gen_count <= gen_ovf ? generator_reload_value : gen_count + 1'b1;
            end
            else
                pre_count <= pre_count + 4'h1;
        end
    end

    // transmitter; a data write while busy is dropped
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_busy <= 1'b0;
            tx_phase <= 1'b0;
            tx_shift <= 11'h7ff;
            tx_bit <= 4'h0;
            tx_sub <= 4'h0;
        end
        else if (!tx_busy)
        begin
            tx_phase <= 1'b0;
            tx_bit <= 4'h0;
            tx_sub <= 4'h0;
            if (bus_wr_data)
            begin
                tx_busy <= 1'b1;
                if (mode0)
                    tx_shift <= {3'h7, avs_writedata[7:0]};
                else
                    tx_shift <= {1'b1, nine ? tx_ninth_bit : 1'b1, avs_writedata[7:0], 1'b0};
            end
        end
        else
        begin
            if (!mode0 && dir_tick[0])
                tx_sub <= tx_sub + 4'h1;
            if (mode0 && m0_tick)
                tx_phase <= !tx_phase;
            if (tx_step)
            begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bit <= tx_bit + 4'h1;
            end
            if (tx_end)
                tx_busy <= 1'b0;
        end
    end

    // receiver state machine
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_state <= RX_IDLE;
            rx_bit <= 4'h0;
            rx_sub <= 4'h0;
            rx_shift <= 9'h000;
            rx_phase <= 1'b0;
        end
        else if (!rx_enable)
            rx_state <= RX_IDLE;
        else
        begin
            if (dir_tick[1])
                rx_sub <= rx_sub + 4'h1;
            case (rx_state)
                RX_IDLE:
                begin
                    rx_bit <= 4'h0;
                    rx_sub <= 4'h0;
                    rx_phase <= 1'b0;
                    if (mode0 && !rx_done_flag && !tx_busy)
                        rx_state <= RX_DATA;
                    else if (!mode0 && rx_prev && !rx_sync)
                        rx_state <= RX_START;
                end
                RX_START:
                    if (dir_tick[1] && rx_sub == `START_MID)
                    begin
                        rx_sub <= 4'h0;
                        rx_state <= rx_sync ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                begin
                    if (mode0 && m0_tick)
                        rx_phase <= !rx_phase;
                    if (rx_smp)
                    begin
                        rx_shift <= rx_next_shift;
                        rx_bit <= rx_bit + 4'h1;
                        if (mode0 ? (rx_bit == `BITS_SHIFT_LAST) : (rx_bit == (nine ? 4'h8 : 4'h7)))
                            rx_state <= mode0 ? RX_IDLE : RX_STOP;
                    end
                end
                RX_STOP:
                    if (rx_smp)
                    begin
                        if (!nine)
                            rx_shift <= rx_next_shift;
                        rx_state <= RX_IDLE;
                    end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // line synchroniser and registered pin drive
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe <= 1'b0;
        end
        else
        begin
            rx_meta <= rxd_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
            // in shift mode the transmit pin carries the clock, low in the first half bit
            if (mode0)
                txd_out <= !((tx_busy && !tx_phase) || (rx_in_data && !rx_phase));
            else
                txd_out <= tx_busy ? tx_shift[0] : 1'b1;
            rxd_out <= tx_shift[0];
            rxd_oe <= mode0 && tx_busy;
        end
    end
endmodule // uart_baud_select_and_control
`default_nettype wire

// *** uart_defs.vh ***
// register map, field positions, reset values and timing counts of the serial port control block
`ifndef UART_DEFS_VH
`define UART_DEFS_VH
// byte offsets on the register bus
`define OFF_SERIAL_CONTROL 8'h98
`define OFF_DATA_BUFFER 8'h9c
`define OFF_RELOAD 8'ha0
`define OFF_GEN_CONTROL 8'ha4
`define OFF_TIMER_TWO 8'ha8
`define OFF_POWER 8'hac
`define OFF_ADDRESS 8'hb0
`define OFF_IRQ_STATUS 8'hb4
`define OFF_IRQ_ENABLE 8'hb8
`define OFF_IRQ_CLEAR 8'hbc
// serial_control fields
`define SC_RX_DONE 0
`define SC_TX_DONE 1
`define SC_RX_NINTH 2
`define SC_TX_NINTH 3
`define SC_RX_ALLOW 4
`define SC_MULTIPROC 5
`define SC_MODE_LOWER 6
`define SC_MODE_UPPER 7
// baud_generator_control fields
`define GC_MODE_ZERO 0
`define GC_FAST 1
`define GC_RX_GEN 2
`define GC_TX_GEN 3
`define GC_RUN 4
// timer_two_control fields
`define T2_TX_SEL 4
`define T2_RX_SEL 5
// power_control fields
`define PW_FRAMING_VIEW 6
`define PW_DOUBLER 7
// interrupt status, enable and clear fields
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_FE 2
// reset values
`define SERIAL_CONTROL_RST 8'h00
`define RELOAD_RST 8'h00
`define ADDRESS_RST 8'h00
`define IRQ_RST 3'h0
// frame modes
`define MODE_SHIFT 2'h0
`define MODE_8BIT 2'h1
`define MODE_9BIT_FIXED 2'h2
`define MODE_9BIT_VAR 2'h3
// timing counts
`define GEN_FAST_DIV 4'h1
`define GEN_SLOW_DIV 4'h6
`define MODE_ZERO_HALF 2'h2
`define SAMPLE_LAST 4'hf
`define START_MID 4'h7
`define BITS_SHIFT_LAST 4'h7
`define BITS_8_LAST 4'h9
`define BITS_9_LAST 4'ha
`endif

// *** uart_defs_unused_guard.v ***
// no logic

// *** uart_ctrl_monitor.sv ***
// assertion checker on the block's ports
`timescale 1ns/1ps
`default_nettype none
module uart_ctrl_monitor (
    input wire sys_clk, // clock
    input wire arst_n, // reset, active low
    input wire [7:0] avs_address, // address
    input wire avs_read, // read
    input wire avs_write, // write
    input wire [31:0] avs_writedata, // write data
    input wire [31:0] avs_readdata, // read data
    input wire avs_waitrequest, // stall
    input wire timer1_overflow, // timer 1 tick
    input wire timer2_overflow, // timer 2 tick
    input wire rxd_in, // receive line
    input wire rxd_out, // shift data
    input wire rxd_oe, // shift drive
    input wire txd_out, // transmit line
    input wire irq // interrupt
);
    reg [7:0] reload_copy;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // last reload written, for readback
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            reload_copy <= 8'h00;
        else if (avs_write && avs_address == 8'ha0)
            reload_copy <= avs_writedata[7:0];
    end
    // a read stalls one cycle, then answers
    sequence s_two_step;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_got(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    AST_READ_WAIT: assert property ($rose(avs_read) |-> s_two_step)
        else $error("read late");
    AST_WRITE_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && avs_address > 8'hbc |-> avs_readdata == 32'h0)
        else $error("unmapped read");
    AST_CLEAR_ZERO: assert property (s_got(8'hbc) |-> avs_readdata == 32'h0)
        else $error("clear read");
    AST_CTRL_UPPER_ZERO: assert property (s_got(8'h98) |-> avs_readdata[31:8] == 24'h0)
        else $error("control upper bits");
    AST_RELOAD_READBACK: assert property (s_got(8'ha0) |-> avs_readdata == {24'h0, reload_copy})
        else $error("reload readback");
    AST_IRQ_MASKED: assert property (avs_write && avs_address == 8'hb8 && avs_writedata[2:0] == 3'h0 |=> !irq)
        else $error("irq while masked");
    AST_IRQ_RESET: assert property ($rose(arst_n) |-> !irq)
        else $error("irq after reset");
endmodule // uart_ctrl_monitor
bind uart_baud_select_and_control uart_ctrl_monitor u_mon (.sys_clk(sys_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer1_overflow(timer1_overflow),
    .timer2_overflow(timer2_overflow), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out), .irq(irq));
`default_nettype wire

// *** remote_node.sv ***
// remote serial node
`timescale 1ns/1ps
`default_nettype none
module remote_node (
    input wire logic sys_clk, // shared clock
    input wire logic txd_out, // line from the block
    output logic rxd_line // line into the block, idles high
);
    initial rxd_line = 1'b1;
    // lsb first, then back to idle high
    task automatic send_frame(input logic [10:0] bits, input int n, input int p);
        for (int i = 0; i < n; i++)
        begin
            rxd_line <= bits[i];
            repeat (p) @(posedge sys_clk);
        end
        rxd_line <= 1'b1;
    endtask
    // mid-bit sampling; bounded wait for the start edge
    task automatic catch_frame(input int n, input int p, output logic [10:0] bits);
        int guard;
        bits = 11'h7ff;
        guard = 0;
        while (txd_out !== 1'b0 && guard < 20000)
        begin
            @(posedge sys_clk);
            guard++;
        end
        repeat (p / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++)
        begin
            bits[i] = txd_out;
            repeat (p) @(posedge sys_clk);
        end
    endtask
endmodule // remote_node
`default_nettype wire

// *** uart_baud_select_and_control_test.sv ***
// self-checking bench
`timescale 1ns/1ps
`default_nettype none
module uart_baud_select_and_control_test;
    logic sys_clk, arst_n, avs_read, avs_write, timer1_overflow, timer2_overflow;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, q, d;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, rxd_out, rxd_oe, txd_out, irq, node_line;
    wire rxd_in = rxd_oe ? rxd_out : node_line; // shared receive wire
    int seed, miscompares, checks, t_count;
    // per case: gen, timer2, power, reload, tx and rx clocks per bit
    logic [7:0] gen_v[7] = '{8'h00, 8'h00, 8'h1e, 8'h1e, 8'h1c, 8'h1a, 8'h16};
    logic [7:0] t2_v[7] = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h30, 8'h10};
    logic [7:0] pw_v[7] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 8'h80, 8'h80};
    logic [7:0] rl_v[7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfe, 8'hff, 8'hff};
    int txp[7] = '{32, 48, 16, 32, 192, 16, 48};
    int rxp[7] = '{32, 48, 16, 32, 192, 48, 16};
    logic [10:0] mp_f[3] = '{{2'b11, 8'h33, 1'b0}, {2'b10, 8'h5a, 1'b0}, {2'b11, 8'h5a, 1'b0}};
    uart_baud_select_and_control dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer1_overflow(timer1_overflow), .timer2_overflow(timer2_overflow),
        .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
    remote_node u_node (.sys_clk(sys_clk), .txd_out(txd_out), .rxd_line(node_line));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // overflow pulses every 2 and 3 clocks so sources differ
    always @(posedge sys_clk)
    begin
        t_count <= t_count + 1;
        timer1_overflow <= (t_count % 2 == 1);
        timer2_overflow <= (t_count % 3 == 2);
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until waitrequest low at an edge
    task automatic bus(input logic wr_n, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= wr_n;
        avs_read <= !wr_n;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        bus(1'b1, a, v, r);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(what, r, exp);
    endtask
    function automatic logic [31:0] ctrl_exp(input logic [7:0] base, input logic tb9, input logic rb9);
        return {24'h0, base | {4'h0, tb9, rb9, 2'h3}};
    endfunction
    task automatic tx_chk(input int n, input int p, input logic [10:0] exp);
        logic [10:0] got;
        fork
            wr(8'h9c, {24'h0, exp[8:1]});
            u_node.catch_frame(n, p, got);
        join
        check("tx frame", {21'h0, got}, {21'h0, exp});
    endtask
    task automatic bit_chk(input string what, input int b, input logic e);
        repeat (4) @(posedge sys_clk);
        bus(1'b0, 8'h98, 32'h0, q);
        check(what, {31'h0, q[b]}, {31'h0, e});
    endtask
    task automatic irq_chk(input logic e);
        @(negedge sys_clk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        {arst_n, avs_read, avs_write, timer1_overflow, timer2_overflow} = 5'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        t_count = 0;
        seed = 70043;
        miscompares = 0;
        checks = 0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk("control reset", 8'h98, 32'h0);
        rd_chk("reload reset", 8'ha0, 32'h0);
        rd_chk("unmapped", 8'hc0, 32'h0);
        // seven clock source pairings, incl. generator/timer 2 each way, mode 1 both ways
        for (int c = 0; c < 7; c++)
        begin
            wr(8'ha0, {24'h0, rl_v[c]});
            wr(8'ha4, {24'h0, gen_v[c]});
            wr(8'ha8, {24'h0, t2_v[c]});
            wr(8'hac, {24'h0, pw_v[c]});
            rd_chk("reload", 8'ha0, {24'h0, rl_v[c]});
            wr(8'h98, 32'h50);
            d = $random(seed);
            tx_chk(10, txp[c], {2'b11, d[7:0], 1'b0});
            d = $random(seed);
            u_node.send_frame({2'b11, d[7:0], 1'b0}, 10, rxp[c]);
            repeat (4) @(posedge sys_clk);
            rd_chk("rx byte", 8'h9c, {24'h0, d[7:0]});
            rd_chk("control", 8'h98, ctrl_exp(8'h50, 1'b0, 1'b1));
        end
        wr(8'ha4, 32'h1e);
        wr(8'ha8, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            d = $random(seed);
            wr(8'h98, k ? 32'hd8 : 32'hd0);
            tx_chk(11, 16, {1'b1, k[0], d[7:0], 1'b0});
            u_node.send_frame({1'b1, d[8], d[7:0], 1'b0}, 11, 16);
            repeat (4) @(posedge sys_clk);
            rd_chk("control", 8'h98, ctrl_exp(8'hd0, k[0], d[8]));
        end
        wr(8'hb0, 32'hff5a);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h98, 32'hf0);
            u_node.send_frame(mp_f[k], 11, 16);
            bit_chk("address filter", 0, k == 2);
        end
        wr(8'h98, 32'h40);
        u_node.send_frame({2'b11, 8'ha5, 1'b0}, 10, 16);
        rd_chk("receive off", 8'h98, 32'h40);
        // bad stop; a later good frame keeps the fault
        wr(8'h98, 32'h50);
        wr(8'hac, 32'hc0);
        u_node.send_frame({2'b10, 8'h3c, 1'b0}, 10, 16);
        bit_chk("fault", 7, 1'b1);
        wr(8'hac, 32'h80);
        bit_chk("mode view", 7, 1'b0);
        wr(8'h98, 32'h50);
        wr(8'hac, 32'hc0);
        u_node.send_frame({2'b11, 8'h3c, 1'b0}, 10, 16);
        bit_chk("fault kept", 7, 1'b1);
        bit_chk("rx done", 0, 1'b1);
        wr(8'h98, 32'h50);
        bit_chk("fault cleared", 7, 1'b0);
        wr(8'hbc, 32'h7);
        rd_chk("status", 8'hb4, 32'h0);
        rd_chk("clear reads zero", 8'hbc, 32'h0);
        wr(8'hb8, 32'h2);
        irq_chk(1'b0);
        tx_chk(10, 16, {2'b11, 8'hc3, 1'b0});
        irq_chk(1'b1);
        rd_chk("status", 8'hb4, 32'h2);
        wr(8'hb8, 32'h0);
        irq_chk(1'b0);
        wr(8'hbc, 32'h2);
        rd_chk("status", 8'hb4, 32'h0);
        tally_and_finish();
    end
endmodule // uart_baud_select_and_control_test
`default_nettype wire
